// ===== inc/nce_pkg.sv
// Constants, opcodes and types shared by the nibble execution core.
package nce_pkg;

	// -----------------------------------------------------------------
	// Widths
	// -----------------------------------------------------------------
	localparam int PC_W       = 14;
	localparam int PAGE_W     = 7;
	localparam int STACK_D    = 8;
	localparam int SIDX_W     = 3;
	localparam int RAMPTR_W   = 10;
	localparam int INSN_W     = 10;

	// -----------------------------------------------------------------
	// Reset values and fixed addresses
	// -----------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RESET    = 14'h0000;
	localparam logic [PAGE_W-1:0] CALL_PAGE   = 7'h02;
	localparam logic [3:0]        NIB_RESET   = 4'h0;
	localparam logic [7:0]        BYTE_RESET  = 8'h00;

	// -----------------------------------------------------------------
	// Opcodes, single-word forms
	// -----------------------------------------------------------------
	localparam logic [9:0] OP_NOP        = 10'h000;
	localparam logic [9:0] OP_POF        = 10'h002;
	localparam logic [9:0] OP_AMC        = 10'h00b;
	localparam logic [9:0] OP_PAIR_TO_WIDE_REG       = 10'h01a;
	localparam logic [9:0] OP_TAD        = 10'h051;
	localparam logic [9:0] OP_TAZ        = 10'h053;
	localparam logic [9:0] OP_TASP       = 10'h050;
	localparam logic [9:0] OP_TDA        = 10'h029;
	localparam logic [9:0] OP_TAB        = 10'h01e;
	localparam logic [9:0] OP_TBA        = 10'h00e;
	localparam logic [9:0] OP_SC         = 10'h007;
	localparam logic [9:0] OP_RC         = 10'h006;
	localparam logic [9:0] OP_SZC        = 10'h02f;
	localparam logic [9:0] OP_RT         = 10'h044;
	localparam logic [9:0] OP_RTS        = 10'h045;
	localparam logic [9:0] OP_RTI        = 10'h046;
	localparam logic [9:0] OP_POWERDOWN_ARM       = 10'h05b;
	localparam logic [9:0] OP_TIMER_LOAD_BOTH       = 10'h230;
	localparam logic [9:0] OP_SST        = 10'h29e;
	localparam logic [9:0] OP_CONVERSION_KICKOFF       = 10'h29f;
	localparam logic [9:0] OP_SERIAL_DONE_SKIP      = 10'h288;
	localparam logic [9:0] OP_SNZAD      = 10'h287;
	localparam logic [9:0] OP_CONV_RESULT_READ      = 10'h279;
	localparam logic [9:0] OP_CONV_LOW_BITS_READ       = 10'h249;
	localparam logic [9:0] OP_WATCHDOG_KICK       = 10'h2a0;

	// -----------------------------------------------------------------
	// Opcode groups: top bits and a field in the low bits
	// -----------------------------------------------------------------
	localparam logic [5:0] GRP_XAM       = 6'h2d;
	localparam logic [5:0] GRP_RAM_SWAP_ROW_UP      = 6'h2e;
	localparam logic [5:0] GRP_RAM_SWAP_ROW_DOWN      = 6'h2f;
	localparam logic [5:0] GRP_LA        = 6'h07;
	localparam logic [7:0] GRP_SB        = 8'h17;
	localparam logic [7:0] GRP_RB        = 8'h13;
	localparam logic [7:0] GRP_SZB       = 8'h08;
	localparam logic [3:0] GRP_ROM_TABLE_READ      = 4'h2;
	localparam logic [2:0] GRP_BM        = 3'h2;
	localparam logic [2:0] GRP_B         = 3'h3;

	typedef enum logic [1:0] {
		NCE_FETCH = 2'b00,
		NCE_TABLE = 2'b01,
		NCE_PARK  = 2'b10
	} nce_state_t;

endpackage : nce_pkg

// ===== core/nce_stack.sv
`timescale 1ns/1ps
// Eight-entry return stack with its index register.
module nce_stack
	import nce_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic                  push,
	input  wire logic                  pop,
	input  wire logic [nce_pkg::PC_W-1:0] push_pc,
	output logic [nce_pkg::PC_W-1:0]   top_pc,
	output logic [nce_pkg::SIDX_W-1:0] stack_index
);
	import nce_pkg::*;

	logic [PC_W-1:0]   return_stack [STACK_D];
	logic [SIDX_W-1:0] idx_r;
	logic [SIDX_W-1:0] idx_up;

	assign idx_up      = idx_r + 3'h1;
	assign top_pc      = return_stack[idx_r];
	assign stack_index = idx_r;

	// -----------------------------------------------------------------
	// Index and entries
	// -----------------------------------------------------------------
	// Push bumps the index first, then writes the entry it now points at.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			idx_r <= 3'h0;
		end else if (push) begin
			idx_r <= idx_up;
		end else if (pop) begin
			idx_r <= idx_r - 3'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			return_stack[idx_up] <= push_pc;
		end
	end

endmodule : nce_stack

// ===== core/nce_alu.sv
`timescale 1ns/1ps
// Nibble adder with carry and single-bit operations on a RAM nibble.
module nce_alu (
	input  wire logic       [3:0] acc,
	input  wire logic       [3:0] mem,
	input  wire logic             carry_in,
	input  wire logic       [1:0] bit_sel,
	output logic            [3:0] sum,
	output logic                  carry_out,
	output logic            [3:0] mem_set,
	output logic            [3:0] mem_clr,
	output logic                  bit_zero
);
	logic [4:0] wide;
	logic [3:0] mask;

	assign wide      = {1'b0, acc} + {1'b0, mem} + {4'h0, carry_in};
	assign sum       = wide[3:0];
	assign carry_out = wide[4];
	assign mask      = 4'h1 << bit_sel;
	assign mem_set   = mem | mask;
	assign mem_clr   = mem & ~mask;
	assign bit_zero  = (mem & mask) == 4'h0;

endmodule : nce_alu

// ===== core/nce_core.sv
`timescale 1ns/1ps
// Instruction execution core of a 4-bit controller.
// How it works
// - Skip turns next instruction into no-op.
// - Skipped instruction always takes one cycle.
// - Program counter 14 bits: page high, offset low.
// - Return stack: eight 14-bit entries, 3-bit index.
// - RAM pointer is file, row, bank concatenated.
// - Table read pushes, jumps via page and offset.
// - Table word to B and A, then pop.
// - Calls bump index, then store program counter.
// - Short call forces page two, operand offset.
// - Returns reload counter from stack, decrement index.
// - Swap A with RAM, file XOR operand.
// - Swap variants step row down or up.
// - Add with carry updates A and carry.
// - Set, clear, test one bit of RAM.
// - Narrow register reads zero-fill high bits.
// - Pair transfer puts B high, A low.
// - Kickoffs clear done flag and start unit.
// - Flag skip tests one, clears after skipping.
// - Result read picks bits by comparator mode.
// - Low-bits read puts two bits high.
// - Watchdog kick clears flag, sets enable.
module nce_core
	import nce_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	output logic [nce_pkg::PC_W-1:0]      rom_addr,
	input  wire logic [nce_pkg::INSN_W-1:0] rom_data,
	output logic [nce_pkg::RAMPTR_W-1:0]  ram_pointer,
	input  wire logic                [3:0] ram_rdata,
	output logic                     [3:0] ram_wdata,
	output logic                           ram_we,
	input  wire logic                      serial_done_set,
	input  wire logic                      conversion_done_set,
	input  wire logic                [9:0] conv_result,
	input  wire logic                      comparator_mode,
	output logic                           serial_start,
	output logic                           conversion_start,
	output logic                     [7:0] timer1_reload,
	output logic                     [7:0] timer1_load,
	output logic                           timer1_load_stb,
	output logic                     [7:0] wide_reg,
	output logic                           carry_flag,
	output logic                           serial_done_flag,
	output logic                           conversion_done_flag,
	output logic                           watchdog_flag,
	input  wire logic                      watchdog_flag_set,
	output logic                           watchdog_enable_flag,
	output logic                           ram_backup_entry,
	output logic [nce_pkg::SIDX_W-1:0]     stack_index
);
	import nce_pkg::*;

	// -----------------------------------------------------------------
	// Architectural state
	// -----------------------------------------------------------------
	logic [PAGE_W-1:0] pc_page_bits_r;
	logic [PAGE_W-1:0] pc_offset_bits_r;
	logic [3:0]        acc_r;
	logic [3:0]        b_r;
	logic [3:0]        file_r;
	logic [3:0]        row_r;
	logic [1:0]        bank_r;
	logic [2:0]        table_offset_reg_r;
	logic [7:0]        wide_r;
	logic              carry_r;
	logic              skip_r;
	logic              arm_r;
	logic              sdone_r;
	logic              cdone_r;
	logic              wdf_r;
	logic              wef_r;
	logic              backup_r;
	logic [7:0]        reload_r;
	nce_state_t        state_r;
	logic [PAGE_W-1:0] table_page_r;

	logic [PC_W-1:0]   pc;
	logic [PC_W-1:0]   pc_inc;
	logic [PC_W-1:0]   top_pc;
	logic [PC_W-1:0]   table_addr;
	logic [9:0]        op;
	logic              run;
	logic              push;
	logic              pop;

	assign pc           = {pc_page_bits_r, pc_offset_bits_r};
	assign pc_inc       = pc + 14'h0001;
	assign ram_pointer  = {file_r, row_r, bank_r};
	assign op           = rom_data;
	assign run          = (state_r == NCE_FETCH) && !skip_r;
	// The page is held from the table read's own fetch, since the bus then carries data.
	assign table_addr   = {table_page_r, table_offset_reg_r, acc_r};
	assign rom_addr     = (state_r == NCE_TABLE) ? table_addr : pc;

	// -----------------------------------------------------------------
	// Decode
	// -----------------------------------------------------------------
	logic is_xam;
	logic is_ram_swap_row_up;
	logic is_ram_swap_row_down;
	logic is_swap;
	logic is_sb;
	logic is_rb;
	logic is_szb;
	logic is_rom_table_read;
	logic is_bm;
	logic is_ret;
	logic is_serial_done_skip;
	logic is_snzad;
	logic [3:0] sum;
	logic       cout;
	logic [3:0] mem_set;
	logic [3:0] mem_clr;
	logic       bit_zero;

	assign is_xam   = op[9:4] == GRP_XAM;
	assign is_ram_swap_row_up  = op[9:4] == GRP_RAM_SWAP_ROW_UP;
	assign is_ram_swap_row_down  = op[9:4] == GRP_RAM_SWAP_ROW_DOWN;
	assign is_swap  = is_xam | is_ram_swap_row_up | is_ram_swap_row_down;
	assign is_sb    = op[9:2] == GRP_SB;
	assign is_rb    = op[9:2] == GRP_RB;
	assign is_szb   = op[9:2] == GRP_SZB;
	assign is_rom_table_read  = op[9:6] == GRP_ROM_TABLE_READ;
	assign is_bm    = op[9:7] == GRP_BM;
	assign is_ret   = (op == OP_RT) | (op == OP_RTS) | (op == OP_RTI);
	assign is_serial_done_skip = op == OP_SERIAL_DONE_SKIP;
	assign is_snzad = op == OP_SNZAD;

	// Single-word forms plus the LA and jump groups, decoded once and shared by the processes below.
	logic is_amc;
	logic is_tad;
	logic is_taz;
	logic is_tasp;
	logic is_tab;
	logic is_tba;
	logic is_la;
	logic is_conv_low_bits_read;
	logic is_conv_result_read;
	logic is_tda;
	logic is_pair_to_wide_reg;
	logic is_sc;
	logic is_rc;
	logic is_szc;
	logic is_sst;
	logic is_conversion_kickoff;
	logic is_watchdog_kick;
	logic is_powerdown_arm;
	logic is_pof;
	logic is_timer_load_both;
	logic is_jump;

	assign is_amc   = op == OP_AMC;
	assign is_tad   = op == OP_TAD;
	assign is_taz   = op == OP_TAZ;
	assign is_tasp  = op == OP_TASP;
	assign is_tab   = op == OP_TAB;
	assign is_tba   = op == OP_TBA;
	assign is_la    = op[9:4] == GRP_LA;
	assign is_conv_low_bits_read  = op == OP_CONV_LOW_BITS_READ;
	assign is_conv_result_read = op == OP_CONV_RESULT_READ;
	assign is_tda   = op == OP_TDA;
	assign is_pair_to_wide_reg  = op == OP_PAIR_TO_WIDE_REG;
	assign is_sc    = op == OP_SC;
	assign is_rc    = op == OP_RC;
	assign is_szc   = op == OP_SZC;
	assign is_sst   = op == OP_SST;
	assign is_conversion_kickoff  = op == OP_CONVERSION_KICKOFF;
	assign is_watchdog_kick  = op == OP_WATCHDOG_KICK;
	assign is_powerdown_arm  = op == OP_POWERDOWN_ARM;
	assign is_pof   = op == OP_POF;
	assign is_timer_load_both  = op == OP_TIMER_LOAD_BOTH;
	assign is_jump  = op[9:7] == GRP_B;

	nce_alu u_alu (
		.acc       (acc_r),
		.mem       (ram_rdata),
		.carry_in  (carry_r),
		.bit_sel   (op[1:0]),
		.sum       (sum),
		.carry_out (cout),
		.mem_set   (mem_set),
		.mem_clr   (mem_clr),
		.bit_zero  (bit_zero)
	);

	// Table read pushes on entry and pops when the word comes back.
	assign push = run && (is_bm || is_rom_table_read);
	assign pop  = (run && is_ret) || (state_r == NCE_TABLE);

	nce_stack u_stack (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.push        (push),
		.pop         (pop),
		.push_pc     (pc_inc),
		.top_pc      (top_pc),
		.stack_index (stack_index)
	);

	// Skip conditions decided by the instruction now executing.
	logic skip_nxt;
	assign skip_nxt = run && (
		(is_szb && bit_zero) ||
		(is_szc && !carry_r) ||
		(op == OP_RTS) ||
		(is_serial_done_skip && sdone_r) ||
		(is_snzad && cdone_r));

	assign ram_we    = run && (is_swap || is_sb || is_rb);
	assign ram_wdata = is_sb ? mem_set : (is_rb ? mem_clr : acc_r);

	// -----------------------------------------------------------------
	// Sequencer and program counter
	// -----------------------------------------------------------------
	// A skipped word costs exactly one cycle, even a table read or return.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r          <= NCE_FETCH;
			pc_page_bits_r   <= PC_RESET[13:7];
			pc_offset_bits_r <= PC_RESET[6:0];
			skip_r           <= 1'b0;
			table_page_r     <= PC_RESET[13:7];
		end else begin
			case (state_r)
				NCE_FETCH: begin
					skip_r <= skip_nxt;
					if (skip_r) begin
						{pc_page_bits_r, pc_offset_bits_r} <= pc_inc;
					end else if (is_rom_table_read) begin
						table_page_r <= PAGE_W'(op[5:0]);
						state_r      <= NCE_TABLE;
					end else if (is_bm) begin
						pc_page_bits_r   <= CALL_PAGE;
						pc_offset_bits_r <= op[6:0];
					end else if (is_jump) begin
						pc_offset_bits_r <= op[6:0];
					end else if (is_ret) begin
						{pc_page_bits_r, pc_offset_bits_r} <= top_pc;
					end else if (is_pof && arm_r) begin
						state_r <= NCE_PARK;
					end else begin
						{pc_page_bits_r, pc_offset_bits_r} <= pc_inc;
					end
				end
				NCE_TABLE: begin
					{pc_page_bits_r, pc_offset_bits_r} <= top_pc;
					state_r <= NCE_FETCH;
				end
				NCE_PARK: begin
					state_r <= NCE_PARK;
				end
				default: begin
					state_r <= NCE_FETCH;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Data registers
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_r <= NIB_RESET;
			b_r   <= NIB_RESET;
		end else if (state_r == NCE_TABLE) begin
			b_r   <= rom_data[7:4];
			acc_r <= rom_data[3:0];
		end else if (run) begin
			if (is_swap) acc_r <= ram_rdata;
			else if (is_amc) acc_r <= sum;
			else if (is_tad) acc_r <= {1'b0, table_offset_reg_r};
			else if (is_taz) acc_r <= {2'b00, bank_r};
			else if (is_tasp) acc_r <= {1'b0, stack_index};
			else if (is_tab) acc_r <= b_r;
			else if (is_la) acc_r <= op[3:0];
			else if (is_conv_low_bits_read) acc_r <= {conv_result[1:0], 2'b00};
			else if (is_conv_result_read) begin
				acc_r <= comparator_mode ? conv_result[3:0] : conv_result[5:2];
				b_r   <= comparator_mode ? conv_result[7:4] : conv_result[9:6];
			end
			if (is_tba) b_r <= acc_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			file_r             <= NIB_RESET;
			row_r              <= NIB_RESET;
			bank_r             <= 2'b00;
			table_offset_reg_r <= 3'h0;
			wide_r             <= BYTE_RESET;
			carry_r            <= 1'b0;
		end else if (run) begin
			if (is_swap) file_r <= file_r ^ op[3:0];
			if (is_ram_swap_row_up) row_r <= row_r + 4'h1;
			if (is_ram_swap_row_down) row_r <= row_r - 4'h1;
			if (is_amc) carry_r <= cout;
			if (is_sc) carry_r <= 1'b1;
			if (is_rc) carry_r <= 1'b0;
			if (is_tda) table_offset_reg_r <= acc_r[2:0];
			if (is_pair_to_wide_reg) wide_r <= {b_r, acc_r};
		end
	end

	// -----------------------------------------------------------------
	// Peripheral flags
	// -----------------------------------------------------------------
	// A done event in the same cycle as a clear wins, so none is lost.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sdone_r  <= 1'b0;
			cdone_r  <= 1'b0;
			wdf_r    <= 1'b0;
			wef_r    <= 1'b0;
			arm_r    <= 1'b0;
			backup_r <= 1'b0;
			reload_r <= BYTE_RESET;
		end else begin
			if (run && (is_sst || (is_serial_done_skip && sdone_r))) sdone_r <= 1'b0;
			if (serial_done_set) sdone_r <= 1'b1;
			if (run && (is_conversion_kickoff || (is_snzad && cdone_r))) cdone_r <= 1'b0;
			if (conversion_done_set) cdone_r <= 1'b1;
			if (run && is_watchdog_kick) begin
				wdf_r <= 1'b0;
				wef_r <= 1'b1;
			end
			if (watchdog_flag_set) wdf_r <= 1'b1;
			// Arming lasts only until the next executed word.
			if (state_r == NCE_FETCH && !skip_r) arm_r <= is_powerdown_arm;
			if (run && is_pof && arm_r) backup_r <= 1'b1;
			if (run && is_timer_load_both) reload_r <= {b_r, acc_r};
		end
	end

	assign serial_start         = run && is_sst;
	assign conversion_start     = run && is_conversion_kickoff;
	assign timer1_load_stb      = run && is_timer_load_both;
	assign timer1_load          = {b_r, acc_r};
	assign timer1_reload        = reload_r;
	assign wide_reg             = wide_r;
	assign carry_flag           = carry_r;
	assign serial_done_flag     = sdone_r;
	assign conversion_done_flag = cdone_r;
	assign watchdog_flag        = wdf_r;
	assign watchdog_enable_flag = wef_r;
	assign ram_backup_entry     = backup_r;

endmodule : nce_core

// ===== dv/nce_mem_model.sv
// Behavioural program ROM and nibble RAM facing the execution core.
`timescale 1ns/1ps
module nce_mem_model
	import nce_pkg::*;
(
	input  wire logic                         core_clk,
	input  wire logic [nce_pkg::PC_W-1:0]     rom_addr,
	output logic      [nce_pkg::INSN_W-1:0]   rom_data,
	input  wire logic [nce_pkg::RAMPTR_W-1:0] ram_pointer,
	output logic      [3:0]                   ram_rdata,
	input  wire logic [3:0]                   ram_wdata,
	input  wire logic                         ram_we
);
	logic [9:0] rom [0:16383];
	logic [3:0] ram [0:1023];

	// Unwritten words read as no-operation so a runaway fetch stays harmless.
	initial begin
		for (int i = 0; i < 16384; i++) rom[i] = 10'h000;
		for (int i = 0; i < 1024; i++) ram[i] = 4'h0;
	end

	assign rom_data  = rom[rom_addr];
	assign ram_rdata = ram[ram_pointer];

	always @(posedge core_clk) begin
		if (ram_we === 1'b1) ram[ram_pointer] <= ram_wdata;
	end
endmodule : nce_mem_model

// ===== dv/nce_core_chk.sv
// Port-level assertions for the execution core.
`timescale 1ns/1ps
module nce_core_chk
	import nce_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [13:0] rom_addr,
	input wire logic [9:0]  rom_data,
	input wire logic [9:0]  ram_pointer,
	input wire logic [3:0]  ram_rdata,
	input wire logic [3:0]  ram_wdata,
	input wire logic        ram_we,
	input wire logic        serial_start,
	input wire logic        serial_done_set,
	input wire logic        serial_done_flag,
	input wire logic [7:0]  timer1_load,
	input wire logic [7:0]  timer1_reload,
	input wire logic        timer1_load_stb,
	input wire logic        watchdog_flag,
	input wire logic        watchdog_enable_flag,
	input wire logic        ram_backup_entry,
	input wire logic [2:0]  stack_index
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	reset_state_a: assert property ($rose(resetn) |-> rom_addr == PC_RESET && stack_index == 3'h0)
		else $error("core not at start after reset");
	stack_step_a: assert property (stack_index != $past(stack_index) |->
		stack_index == $past(stack_index) + 3'h1 || stack_index == $past(stack_index) - 3'h1)
		else $error("stack index jumped");
	page2_call_a: assert property (stack_index == $past(stack_index) + 3'h1 &&
		$past(rom_data[9:7]) == GRP_BM |-> rom_addr == {CALL_PAGE, $past(rom_data[6:0])})
		else $error("short call target wrong");
	serial_clear_a: assert property (serial_start |=> !serial_done_flag || $past(serial_done_set))
		else $error("serial done flag not cleared");
	timer_load_a: assert property (timer1_load_stb |=> timer1_reload == $past(timer1_load))
		else $error("timer reload not loaded");
	watchdog_kick_a: assert property ($fell(watchdog_flag) |-> watchdog_enable_flag)
		else $error("watchdog enable not set");
	swap_file_a: assert property (ram_we && rom_data[9:4] == GRP_XAM |=>
		ram_pointer == {$past(ram_pointer[9:6] ^ rom_data[3:0]), $past(ram_pointer[5:0])})
		else $error("swap file update wrong");
	swap_down_a: assert property (ram_we && rom_data[9:4] == GRP_RAM_SWAP_ROW_DOWN |=>
		ram_pointer[5:2] == $past(ram_pointer[5:2]) - 4'h1)
		else $error("row not decremented");
	bit_set_a: assert property (ram_we && rom_data[9:2] == GRP_SB |->
		ram_wdata == (ram_rdata | (4'h1 << rom_data[1:0])))
		else $error("bit set value wrong");
	bit_clear_a: assert property (ram_we && rom_data[9:2] == GRP_RB |->
		ram_wdata == (ram_rdata & ~(4'h1 << rom_data[1:0])))
		else $error("bit clear value wrong");
	backup_arm_a: assert property ($rose(ram_backup_entry) |->
		$past(rom_data) == OP_POF && $past(rom_data, 2) == OP_POWERDOWN_ARM)
		else $error("backup entered without arming");
endmodule : nce_core_chk

bind nce_core nce_core_chk i_chk (.core_clk(core_clk), .resetn(resetn), .rom_addr(rom_addr),
	.rom_data(rom_data), .ram_pointer(ram_pointer), .ram_rdata(ram_rdata),
	.ram_wdata(ram_wdata), .ram_we(ram_we), .serial_start(serial_start),
	.serial_done_set(serial_done_set), .serial_done_flag(serial_done_flag),
	.timer1_load(timer1_load), .timer1_reload(timer1_reload),
	.timer1_load_stb(timer1_load_stb), .watchdog_flag(watchdog_flag),
	.watchdog_enable_flag(watchdog_enable_flag), .ram_backup_entry(ram_backup_entry),
	.stack_index(stack_index));

// ===== dv/nibble_cpu_instruction_exec_tb.sv
// Self-checking bench running a short program through the execution core.
`timescale 1ns/1ps
module nibble_cpu_instruction_exec_tb;
	import nce_pkg::*;
	logic core_clk = 1'b0, resetn = 1'b0, serial_done_set = 1'b0, watchdog_flag_set = 1'b0;
	logic [13:0] rom_addr;
	logic [9:0] rom_data, ram_pointer;
	logic [3:0] ram_rdata, ram_wdata;
	logic ram_we, serial_start, conversion_start, timer1_load_stb, carry_flag;
	logic serial_done_flag, conversion_done_flag, watchdog_flag, watchdog_enable_flag;
	logic ram_backup_entry;
	logic [7:0] timer1_reload, timer1_load, wide_reg;
	logic [2:0] stack_index;
	logic [1:0] sd_q = 2'b00;
	logic conversion_done_set = 1'b0, comparator_mode = 1'b0;
	int cs_cnt = 0;
	int err_count = 0, cmp_count = 0, cyc = 0, t0;
	// Program: swaps, carry add, bit ops, skip, table read, call, flags, power-down.
	localparam logic [9:0] PROG [0:36] = '{10'h075, 10'h029, 10'h073, 10'h2d1, 10'h00e,
		10'h076, 10'h01a, 10'h007, 10'h00b, 10'h230, 10'h2f0, 10'h2e0, 10'h04e, 10'h05e,
		10'h04c, 10'h020, 10'h07f, 10'h01a, 10'h083, 10'h01a, 10'h110, 10'h29e, 10'h002,
		10'h29f, 10'h001, 10'h288, 10'h07f, 10'h01a, 10'h2a0, 10'h279, 10'h01a, 10'h249,
		10'h01a, 10'h051, 10'h230, 10'h05b, 10'h002};

	always #4 core_clk = ~core_clk;

	nce_core i_dut (.core_clk(core_clk), .resetn(resetn), .rom_addr(rom_addr),
		.rom_data(rom_data), .ram_pointer(ram_pointer), .ram_rdata(ram_rdata),
		.ram_wdata(ram_wdata), .ram_we(ram_we), .serial_done_set(serial_done_set),
		.conversion_done_set(conversion_done_set), .conv_result(10'h1e5),
		.comparator_mode(comparator_mode),
		.serial_start(serial_start), .conversion_start(conversion_start),
		.timer1_reload(timer1_reload), .timer1_load(timer1_load),
		.timer1_load_stb(timer1_load_stb), .wide_reg(wide_reg), .carry_flag(carry_flag),
		.serial_done_flag(serial_done_flag), .conversion_done_flag(conversion_done_flag),
		.watchdog_flag(watchdog_flag), .watchdog_flag_set(watchdog_flag_set),
		.watchdog_enable_flag(watchdog_enable_flag), .ram_backup_entry(ram_backup_entry),
		.stack_index(stack_index));

	nce_mem_model i_mem (.core_clk(core_clk), .rom_addr(rom_addr), .rom_data(rom_data),
		.ram_pointer(ram_pointer), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata),
		.ram_we(ram_we));

	// The serial unit reports completion three cycles after it is started.
	always @(posedge core_clk) begin
		sd_q <= {sd_q[0], serial_start === 1'b1};
		serial_done_set <= #1 sd_q[1];
		conversion_done_set <= #1 (conversion_start === 1'b1);
		if (conversion_start === 1'b1) cs_cnt <= cs_cnt + 1;
	end

	// A hang is cut short at cycle 2000, well beyond the seventy-eight cycles the program needs.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			final_report();
		end
	end

	task automatic check_val(input logic [13:0] got, input logic [13:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic run_to(input logic [13:0] addr);
		int n;
		n = 0;
		while (rom_addr !== addr && n < 200) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check_val(rom_addr, addr);
	endtask : run_to

	task automatic do_reset();
		resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 resetn = 1'b1;
	endtask : do_reset

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	initial begin
		for (int i = 0; i < 37; i++) i_mem.rom[i] = PROG[i];
		i_mem.rom[14'h110] = OP_RT;
		i_mem.rom[14'h1d1] = 10'h0a7;
		i_mem.ram[0] = 4'h9;
		i_mem.ram[10'h040] = 4'h8;
		i_mem.ram[10'h07c] = 4'h1;
		do_reset();
		check_val(rom_addr, PC_RESET);
		watchdog_flag_set = 1'b1;
		@(posedge core_clk);
		#1 watchdog_flag_set = 1'b0;
		run_to(14'h04);
		check_val(14'(ram_pointer), 14'h040);
		check_val(14'(i_mem.ram[0]), 14'h3);
		run_to(14'h07);
		check_val(14'(wide_reg), 14'h96);
		run_to(14'h0a);
		check_val(14'(timer1_reload), 14'h9f);
		check_val(14'(carry_flag), 14'h0);
		run_to(14'h0b);
		check_val(14'(ram_pointer), 14'h07c);
		run_to(14'h0c);
		check_val(14'(ram_pointer), 14'h040);
		run_to(14'h0f);
		t0 = cyc;
		run_to(14'h12);
		check_val(14'(cyc - t0), 14'h3);
		check_val(14'(wide_reg), 14'h91);
		check_val(14'(i_mem.ram[10'h040]), 14'he);
		t0 = cyc;
		run_to(14'h13);
		check_val(14'(cyc - t0), 14'h2);
		run_to(14'h14);
		check_val(14'(wide_reg), 14'ha7);
		check_val(14'(stack_index), 14'h0);
		run_to(14'h110);
		check_val(14'(stack_index), 14'h1);
		run_to(14'h15);
		check_val(14'(stack_index), 14'h0);
		run_to(14'h19);
		check_val(14'(ram_backup_entry), 14'h0);
		run_to(14'h1c);
		check_val(14'(wide_reg), 14'ha7);
		check_val(14'(serial_done_flag), 14'h0);
		check_val(14'(conversion_done_flag), 14'h1);
		check_val(14'(watchdog_flag), 14'h1);
		run_to(14'h1d);
		check_val(14'({watchdog_flag, watchdog_enable_flag}), 14'h1);
		run_to(14'h1f);
		check_val(14'(wide_reg), 14'h79);
		run_to(14'h21);
		check_val(14'(wide_reg), 14'h74);
		run_to(14'h23);
		check_val(14'(timer1_reload), 14'h75);
		run_to(14'h24);
		repeat (3) @(posedge core_clk);
		#1 check_val(14'(ram_backup_entry), 14'h1);
		comparator_mode = 1'b1;
		do_reset();
		check_val(rom_addr, PC_RESET);
		check_val(14'({ram_backup_entry, wide_reg}), 14'h0);
		run_to(14'h1f);
		check_val(14'(wide_reg), 14'he5);
		check_val(14'(cs_cnt), 14'h2);
		final_report();
	end
endmodule : nibble_cpu_instruction_exec_tb
